// ---- design/pdr_unit.sv ----
// page descriptor storage, flag upkeep, relocation and console address display
`timescale 1ns/100ps
// Summary of operation
// - three descriptor sets, kernel, supervisor, user, each sixteen 16-bit registers
// - descriptor holds page length, attention, written, growth direction, access key
// - exactly one set enabled; unselected sets do not disturb shared outputs
// - set chosen by its descriptor address, its base address, or space control
// - qualified write loads length, direction and key from data bits 14:8, 3:0
// - flag store has own strobe: relocated non-internal access or table write
// - attention flag set when a trap condition arises on that page
// - written flag set when a write cycle touches that page
// - stored flags loaded into holding flip-flops at bus cycle T5
// - at pause T4 holding flags written back, ORed with new events
// - no flag is set on an aborted access or internal register access
// - table write forces flag data low, clearing both flags
// - read mux gives page base when address bit 4 high, else descriptor
// - adder sums block number bits 12:6 with 12-bit page base
// - relocation on drives adder result; off passes virtual bits 15:6
// - relocation off sets physical bits 17:16 only for the I/O page
// - console display bits 5:0 always virtual bits 5:0
// - display bits 15:6 chosen by relocation state and selector position
// - display bits 17:16 from relocation, selector, switches and I/O flag
// - console selector decoded with control ROM bit sets space flip-flops
// - trap on read with key 1, write with key 5, any access key 4
// - full physical address is physAddr 17:6, relocated or passed through, plus virtual 5:0
module pdr_unit
    import pdr_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdata,
    // processor address and cycle timing
    input wire logic [15:0] virtualAddressBus,
    input wire logic [11:0] pageBaseField,
    input wire logic busT5,
    input wire logic pauseT4,
    input wire logic writeCycle,
    input wire logic abortCond,
    input wire logic internalRef,
    input wire logic [1:0] procMode,
    input wire logic procDataSpace,
    input wire logic controlRomConsoleBit,
    // console pins
    input wire logic [2:0] displaySelectorCode,
    input wire logic [1:0] consoleSwitchHigh,
    // address and status outputs
    output logic [17:6] physAddr,
    output logic [17:0] physAddrFull,
    output logic ioPageFlag,
    output logic memMgmtTrap,
    output logic [2:0] spaceSelect,
    output logic dataSpace,
    output logic [17:0] consoleDisplayAddress
);
    logic relocEnable;
    logic relocationOn_n;
    logic [2:0] selMeta;
    pdr_display_sel_t selSync;
    logic [1:0] switchMeta;
    logic [1:0] switchSync;
    logic [1:0] regMode;
    logic regInDesc;
    logic regHit;
    logic baseSelect;
    logic [3:0] descIdx;
    logic [2:0] chipSel;
    logic [15:0] descOut [NUM_SETS];
    logic [15:0] selDesc;
    logic [2:0] accessKey;
    logic trapNow;
    logic attentionHold;
    logic writtenHold;
    logic trapHold;
    logic relocAccess;
    logic flagStoreWrite_n;
    logic [1:0] flagData;
    logic [11:0] adderSum;

    pdr_set_if setBus [NUM_SETS] ();

    assign relocationOn_n = !relocEnable;
    assign relocAccess = !relocationOn_n && !internalRef;

    // console pins are asynchronous to the processor clock
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            selMeta <= 3'h0;
            selSync <= SEL_PROGRAM_PHYSICAL_VIEW;
            switchMeta <= 2'h0;
            switchSync <= 2'h0;
        end else begin
            selMeta <= displaySelectorCode;
            selSync <= pdr_display_sel_t'(selMeta);
            switchMeta <= consoleSwitchHigh;
            switchSync <= switchMeta;
        end
    end

    // space control: console positions other than the two physical views win while the control ROM grants it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            spaceSelect <= SPACE_KERNEL;
            dataSpace <= 1'b0;
        end else if (controlRomConsoleBit && selSync != SEL_PROGRAM_PHYSICAL_VIEW
                     && selSync != SEL_CONSOLE_PHYSICAL_VIEW) begin
            dataSpace <= selSync[0];
            case (selSync)
                SEL_KERNEL_I, SEL_KERNEL_D: begin
                    spaceSelect <= SPACE_KERNEL;
                end
                SEL_SUPER_I, SEL_SUPER_D: begin
                    spaceSelect <= SPACE_SUPER;
                end
                default: begin
                    spaceSelect <= SPACE_USER;
                end
            endcase
        end else begin
            dataSpace <= procDataSpace;
            case (procMode)
                MODE_KERNEL: begin
                    spaceSelect <= SPACE_KERNEL;
                end
                MODE_SUPER: begin
                    spaceSelect <= SPACE_SUPER;
                end
                default: begin
                    spaceSelect <= SPACE_USER;
                end
            endcase
        end
    end

    // register decode: [6:5] mode, [4] base or descriptor, [3:0] index
    assign regMode = regAddr[ADDR_MODE_LSB +: 2];
    assign regInDesc = regAddr <= ADDR_DESC_LAST;
    assign regHit = (regWrite || regRead) && regInDesc;
    assign baseSelect = regAddr[ADDR_BASE_BIT];

    // a table access outranks the space signals for that cycle
    always_comb begin
        if (regHit) begin
            chipSel = 3'h1 << regMode;
            descIdx = regAddr[3:0];
        end else begin
            chipSel = spaceSelect;
            descIdx = {dataSpace, virtualAddressBus[15:13]};
        end
    end

    // flag data is forced low for any table write, so writes clear flags
    always_comb begin
        if (regWrite && regHit) begin
            flagStoreWrite_n = 1'b0;
            flagData = 2'h0;
        end else if (pauseT4 && relocAccess) begin
            flagStoreWrite_n = 1'b0;
            flagData = {attentionHold | (trapHold && !abortCond),
                        writtenHold | (writeCycle && !abortCond)};
        end else begin
            flagStoreWrite_n = 1'b1;
            flagData = 2'h0;
        end
    end

    for (genvar g = 0; g < NUM_SETS; g++) begin : g_set
        assign setBus[g].chipSel = chipSel[g];
        assign setBus[g].regIdx = descIdx;
        assign setBus[g].fieldWrite = regWrite && regHit && !baseSelect;
        assign setBus[g].fieldData = regWdata;
        assign setBus[g].flagWrite = !flagStoreWrite_n;
        assign setBus[g].flagData = flagData;
        assign descOut[g] = setBus[g].readData;
        pdr_desc_set u_set (
            .clk_sys (clk_sys),
            .rst_n (rst_n),
            .bus (setBus[g].store)
        );
    end

    // sets are wire-ORed; only the enabled one is non-zero
    always_comb begin
        selDesc = 16'h0000;
        for (int s = 0; s < NUM_SETS; s++) begin
            selDesc = selDesc | descOut[s];
        end
    end

    assign accessKey = selDesc[ACF_MSB:ACF_LSB];
    assign trapNow = (accessKey == KEY_TRAP_ANY)
                   || (accessKey == KEY_TRAP_READ && !writeCycle)
                   || (accessKey == KEY_TRAP_WRITE && writeCycle);

    // holding flip-flops keep flags already set across the cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            attentionHold <= 1'b0;
            writtenHold <= 1'b0;
            trapHold <= 1'b0;
        end else if (busT5 && relocAccess && !regHit) begin
            attentionHold <= selDesc[ATTENTION_HOLD_FF_BIT];
            writtenHold <= selDesc[WRTN_BIT];
            trapHold <= trapNow;
        end
    end
    assign memMgmtTrap = trapHold;

    // relocation path stays combinational so it settles within the cycle
    assign adderSum = pageBaseField + {5'h00, virtualAddressBus[12:6]};
    assign ioPageFlag = &virtualAddressBus[15:13];
    always_comb begin
        if (!relocationOn_n) begin
            physAddr = adderSum;
        end else begin
            physAddr = {{2{ioPageFlag}}, virtualAddressBus[15:6]};
        end
    end
    assign physAddrFull = {physAddr, virtualAddressBus[5:0]};

    // program physical shows whatever the bus carries, relocated or not
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            consoleDisplayAddress <= 18'h00000;
        end else begin
            consoleDisplayAddress[5:0] <= virtualAddressBus[5:0];
            case (selSync)
                SEL_PROGRAM_PHYSICAL_VIEW: begin
                    consoleDisplayAddress[17:6] <= physAddr;
                end
                SEL_CONSOLE_PHYSICAL_VIEW: begin
                    consoleDisplayAddress[17:6] <= {switchSync,
                                                    virtualAddressBus[15:6]};
                end
                default: begin
                    consoleDisplayAddress[17:6] <= {2'h0,
                                                    virtualAddressBus[15:6]};
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            relocEnable <= CTRL_RELOC_RESET;
        end else if (regWrite && regAddr == ADDR_CTRL) begin
            relocEnable <= regWdata[CTRL_RELOC_BIT];
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            regRdata <= 16'h0000;
        end else if (!regRead) begin
            regRdata <= 16'h0000;
        end else if (regInDesc) begin
            regRdata <= baseSelect ? {4'h0, pageBaseField} : selDesc;
        end else if (regAddr == ADDR_CTRL) begin
            regRdata <= {15'h0000, relocEnable};
        end else if (regAddr == ADDR_STATUS) begin
            regRdata <= {8'h00, spaceSelect, dataSpace, 1'b0, trapHold,
                         attentionHold, writtenHold};
        end else begin
            regRdata <= 16'h0000;
        end
    end

    a_one_set_enabled: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $onehot(chipSel))
        else $error("descriptor set enable not one-hot");

    a_reg_selects_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        regHit |-> chipSel[regMode])
        else $error("table access did not select its set");

    a_reloc_adder: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !relocationOn_n |-> physAddr == pageBaseField + {5'h00, virtualAddressBus[12:6]})
        else $error("relocated address wrong");

    a_io_page_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
        relocationOn_n |-> physAddr == {{2{&virtualAddressBus[15:13]}},
                                        virtualAddressBus[15:6]})
        else $error("unrelocated address wrong");

    a_display_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 consoleDisplayAddress[5:0] == $past(virtualAddressBus[5:0]))
        else $error("display low bits not virtual");

    a_hold_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
        busT5 && relocAccess && !regHit |=> attentionHold == $past(selDesc[ATTENTION_HOLD_FF_BIT])
            && writtenHold == $past(selDesc[WRTN_BIT]))
        else $error("holding flags not captured at T5");

    a_write_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        regWrite && regHit |-> !flagStoreWrite_n && flagData == 2'h0)
        else $error("table write did not clear flags");

    a_abort_no_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pauseT4 && relocAccess && abortCond && !(regWrite && regHit)
            |-> flagData == {attentionHold, writtenHold})
        else $error("flag set on aborted access");

    a_written_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pauseT4 && relocAccess && writeCycle && !abortCond && !(regWrite && regHit)
            |-> flagData[0] && !flagStoreWrite_n)
        else $error("written flag not set");

    a_trap_any_key: assert property (@(posedge clk_sys) disable iff (!rst_n)
        busT5 && relocAccess && !regHit && accessKey == KEY_TRAP_ANY |=> memMgmtTrap)
        else $error("key 4 did not trap");

    a_trap_read_key: assert property (@(posedge clk_sys) disable iff (!rst_n)
        busT5 && relocAccess && !regHit && accessKey == KEY_TRAP_READ && !writeCycle
            |=> memMgmtTrap)
        else $error("key 1 read did not trap");

    a_trap_write_key: assert property (@(posedge clk_sys) disable iff (!rst_n)
        busT5 && relocAccess && !regHit && accessKey == KEY_TRAP_WRITE && writeCycle
            |=> memMgmtTrap)
        else $error("key 5 write did not trap");

    a_attention_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pauseT4 && relocAccess && trapHold && !abortCond && !(regWrite && regHit)
            |-> flagData[1] && !flagStoreWrite_n)
        else $error("attention flag not set");

    a_hold_written_back: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pauseT4 && relocAccess && !(regWrite && regHit)
            |-> !flagStoreWrite_n && (flagData & {attentionHold, writtenHold})
                == {attentionHold, writtenHold})
        else $error("held flags lost at write-back");

    a_base_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        regRead && regInDesc && baseSelect |=> regRdata == {4'h0, $past(pageBaseField)})
        else $error("page base not returned on base read");

    a_console_switches: assert property (@(posedge clk_sys) disable iff (!rst_n)
        selSync == SEL_CONSOLE_PHYSICAL_VIEW |=> consoleDisplayAddress[17:16] == $past(switchSync))
        else $error("display high bits not from switches");

    a_console_user: assert property (@(posedge clk_sys) disable iff (!rst_n)
        controlRomConsoleBit && (selSync == SEL_USER_I || selSync == SEL_USER_D)
            |=> spaceSelect == SPACE_USER && dataSpace == $past(selSync[0]))
        else $error("console user position did not set space");
endmodule : pdr_unit

// ---- shared/pdr_pkg.sv ----
// constants and types shared by the page descriptor unit
package pdr_pkg;
    localparam int NUM_SETS = 3;
    localparam int DESC_PER_SET = 16;
    // register port map
    localparam logic [7:0] ADDR_DESC_LAST = 8'h5F;
    localparam logic [7:0] ADDR_CTRL = 8'h60;
    localparam logic [7:0] ADDR_STATUS = 8'h61;
    localparam int ADDR_MODE_LSB = 5;
    localparam int ADDR_BASE_BIT = 4;
    localparam int CTRL_RELOC_BIT = 0;
    localparam logic CTRL_RELOC_RESET = 1'b0;
    // descriptor word layout
    localparam int PLF_LSB = 8;
    localparam int PLF_MSB = 14;
    localparam int ATTENTION_HOLD_FF_BIT = 7;
    localparam int WRTN_BIT = 6;
    localparam int ED_BIT = 3;
    localparam int ACF_MSB = 2;
    localparam int ACF_LSB = 0;
    localparam logic [15:0] FIELD_MASK = 16'h7F0F;
    // access keys that raise a memory management trap
    localparam logic [2:0] KEY_TRAP_READ = 3'h1;
    localparam logic [2:0] KEY_TRAP_ANY = 3'h4;
    localparam logic [2:0] KEY_TRAP_WRITE = 3'h5;
    // processor mode codes and one-hot space bits
    localparam logic [1:0] MODE_KERNEL = 2'h0;
    localparam logic [1:0] MODE_SUPER = 2'h1;
    localparam logic [1:0] MODE_USER = 2'h3;
    localparam logic [2:0] SPACE_KERNEL = 3'h1;
    localparam logic [2:0] SPACE_SUPER = 3'h2;
    localparam logic [2:0] SPACE_USER = 3'h4;
    typedef enum logic [2:0] {
        SEL_PROGRAM_PHYSICAL_VIEW = 3'h0,
        SEL_CONSOLE_PHYSICAL_VIEW = 3'h1,
        SEL_KERNEL_I = 3'h2,
        SEL_KERNEL_D = 3'h3,
        SEL_SUPER_I = 3'h4,
        SEL_SUPER_D = 3'h5,
        SEL_USER_I = 3'h6,
        SEL_USER_D = 3'h7
    } pdr_display_sel_t;
endpackage : pdr_pkg

// ---- shared/pdr_set_if.sv ----
// link between the unit and one descriptor set
`timescale 1ns/100ps
interface pdr_set_if;
    logic chipSel;
    logic [3:0] regIdx;
    logic fieldWrite;
    logic [15:0] fieldData;
    logic flagWrite;
    logic [1:0] flagData;
    logic [15:0] readData;
    modport unit (output chipSel, regIdx, fieldWrite, fieldData, flagWrite, flagData,
                  input readData);
    modport store (input chipSel, regIdx, fieldWrite, fieldData, flagWrite, flagData,
                   output readData);
endinterface : pdr_set_if

// ---- design/pdr_desc_set.sv ----
// one mode's set of sixteen page descriptors
`timescale 1ns/100ps
module pdr_desc_set
    import pdr_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // unit side
    pdr_set_if.store bus
);
    logic [15:0] fieldMem [DESC_PER_SET];
    logic [1:0] flagMem [DESC_PER_SET];
    logic [15:0] word;

    // fields are plain storage; only the flags need a known start
    always_ff @(posedge clk_sys) begin
        if (bus.chipSel && bus.fieldWrite) begin
            fieldMem[bus.regIdx] <= bus.fieldData & FIELD_MASK;
        end
    end

    // flag bits sit in their own store with a separate strobe
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < DESC_PER_SET; i++) begin
                flagMem[i] <= 2'h0;
            end
        end else if (bus.chipSel && bus.flagWrite) begin
            flagMem[bus.regIdx] <= bus.flagData;
        end
    end

    always_comb begin
        word = fieldMem[bus.regIdx];
        word[ATTENTION_HOLD_FF_BIT] = flagMem[bus.regIdx][1];
        word[WRTN_BIT] = flagMem[bus.regIdx][0];
    end

    // a deselected set drives zero so the shared lines stay clean
    assign bus.readData = bus.chipSel ? word : 16'h0000;
endmodule : pdr_desc_set

// ---- verif/pdr_cpu_model.sv ----
// processor core model issuing bus cycles with T5 and pause T4 pulses
`timescale 1ns/100ps
module pdr_cpu_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // bench commands
    input wire logic go,
    input wire logic [15:0] goVa,
    input wire logic goWrite,
    input wire logic slow,
    // processor side
    output logic [15:0] virtualAddressBus,
    output logic writeCycle,
    output logic busT5,
    output logic pauseT4,
    output logic done
);
    logic [3:0] step;
    logic [3:0] lastStep;
    assign lastStep = slow ? 4'h9 : 4'h4;
    always_ff @(posedge clk_sys) begin
        // T5 always precedes T4; the slow form stretches the gap between them
        busT5 <= rst_n && (step == 4'h1);
        pauseT4 <= rst_n && (step == lastStep - 4'h1);
        done <= rst_n && (step == lastStep);
        if (!rst_n) begin
            step <= 4'h0;
            virtualAddressBus <= 16'h0000;
            writeCycle <= 1'b0;
        end else if (step == 4'h0) begin
            if (go) begin
                // address and direction held from T5 through the write-back
                virtualAddressBus <= goVa;
                writeCycle <= goWrite;
                step <= 4'h1;
            end
        end else begin
            step <= (step == lastStep) ? 4'h0 : step + 4'h1;
        end
    end
endmodule : pdr_cpu_model

// ---- verif/pdr_unit_tb.sv ----
// self-checking bench for the page descriptor unit
`timescale 1ns/100ps
module pdr_unit_tb;
    import pdr_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWdata = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [11:0] pageBaseField = 12'h000;
    logic abortCond = 1'b0;
    logic internalRef = 1'b1;
    logic controlRomConsoleBit = 1'b0;
    logic [2:0] displaySelectorCode = 3'h0;
    logic [1:0] consoleSwitchHigh = 2'h0;
    logic go = 1'b0;
    logic [15:0] goVa = 16'h0000;
    logic goWrite = 1'b0;
    logic slow = 1'b0;
    logic [1:0] procMode = MODE_KERNEL;
    logic procDataSpace = 1'b0;
    logic [15:0] regRdata, va;
    logic busT5, pauseT4, writeCycle, done, ioPageFlag, memMgmtTrap, dataSpace;
    logic [17:6] physAddr;
    logic [17:0] physAddrFull, consoleDisplayAddress;
    logic [2:0] spaceSelect;
    int n_fail = 0;
    int check_count = 0;

    always #12.5 clk_sys = ~clk_sys;

    pdr_unit pdr_unit_inst (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .virtualAddressBus(va), .pageBaseField(pageBaseField), .busT5(busT5),
        .pauseT4(pauseT4), .writeCycle(writeCycle), .abortCond(abortCond),
        .internalRef(internalRef), .procMode(procMode), .procDataSpace(procDataSpace),
        .controlRomConsoleBit(controlRomConsoleBit), .displaySelectorCode(displaySelectorCode),
        .consoleSwitchHigh(consoleSwitchHigh), .physAddr(physAddr), .physAddrFull(physAddrFull),
        .ioPageFlag(ioPageFlag), .memMgmtTrap(memMgmtTrap), .spaceSelect(spaceSelect),
        .dataSpace(dataSpace), .consoleDisplayAddress(consoleDisplayAddress));

    pdr_cpu_model pdr_cpu_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .go(go), .goVa(goVa),
        .goWrite(goWrite), .slow(slow), .virtualAddressBus(va), .writeCycle(writeCycle),
        .busT5(busT5), .pauseT4(pauseT4), .done(done));

    function automatic logic [7:0] dadr(int s, int i, logic b);
        return {1'b0, s[1:0], b, i[3:0]};
    endfunction : dadr

    function automatic logic [15:0] dexp(logic [15:0] d, logic a, logic w);
        return (d & FIELD_MASK) | {8'h00, a, w, 6'h00};
    endfunction : dexp

    function automatic logic trapx(logic [2:0] k, logic w);
        return (k == 3'h4) || (k == 3'h1 && !w) || (k == 3'h5 && w);
    endfunction : trapx

    function automatic logic [17:0] physx(logic [15:0] v, logic [11:0] b, logic r);
        if (r) return {b + {5'h00, v[12:6]}, v[5:0]};
        return {{2{&v[15:13]}}, v};
    endfunction : physx

    task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask : reg_rd

    // one processor access; a hang counts as a mismatch rather than stalling the run
    task automatic access(input logic [15:0] v, input logic wr, input logic intr, input logic ab);
        int n;
        @(posedge clk_sys);
        goVa <= v;
        goWrite <= wr;
        internalRef <= intr;
        abortCond <= ab;
        slow <= wr;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (done !== 1'b1 && n < 40);
        if (n >= 40) n_fail++;
    endtask : access

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        logic [15:0] rd, v;
        logic [15:0] fld [0:47];
        logic [11:0] b;
        logic [1:0] sw;
        logic t;
        void'($urandom(32'hAD49));
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        reg_rd(ADDR_STATUS, rd);
        check("status after reset", 16'h0020, rd);
        @(posedge clk_sys);
        #1;
        check("read data after its cycle", 16'h0000, regRdata);
        reg_rd(ADDR_CTRL, rd);
        check("ctrl after reset", 16'h0000, rd);
        // fill all three sets before reading, so a leaking set shows up
        for (int k = 0; k < 48; k++) begin
            fld[k] = (k == 0) ? 16'hFFFF : 16'($urandom);
            reg_wr(dadr(k / 16, k % 16, 1'b0), fld[k]);
        end
        for (int k = 0; k < 48; k++) begin
            reg_rd(dadr(k / 16, k % 16, 1'b0), rd);
            check("descriptor", dexp(fld[k], 1'b0, 1'b0), rd);
        end
        b = 12'($urandom);
        pageBaseField <= b;
        reg_rd(dadr(2, 7, 1'b1), rd);
        check("base read", {4'h0, b}, rd);
        reg_wr(8'h62, 16'hFFFF);
        reg_rd(8'h62, rd);
        check("unmapped read", 16'h0000, rd);
        for (int k = 0; k < 32; k++) begin
            if (k % 16 == 0) reg_wr(ADDR_CTRL, 16'(k / 16));
            v = (k % 16 < 2) ? (16'hE000 | 16'($urandom)) : 16'($urandom);
            b = (k == 16) ? 12'hFFF : 12'($urandom);
            pageBaseField <= b;
            access(v, 1'b0, 1'b1, 1'b0);
            check("phys full", physx(v, b, k / 16), physAddrFull);
            check("phys high", physx(v, b, k / 16) >> 6, physAddr);
            check("io page flag", &v[15:13], ioPageFlag);
        end
        // key from 0 to 7, read then write access, each on its own page
        for (int k = 0; k < 16; k++) begin
            v = {k[3:1], 13'($urandom)};
            fld[k / 2] = (16'($urandom) & 16'hFFF8) | 16'(k / 2);
            reg_wr(dadr(0, k / 2, 1'b0), fld[k / 2]);
            access(v, k[0], 1'b0, 1'b0);
            t = trapx(v[15:13], k[0]);
            check("trap", t, memMgmtTrap);
            reg_rd(dadr(0, k / 2, 1'b0), rd);
            check("flags set", dexp(fld[k / 2], t, k[0]), rd);
            access(v, 1'b1, 1'b0, 1'b1);
            reg_rd(dadr(0, k / 2, 1'b0), rd);
            check("flags kept", dexp(fld[k / 2], t, k[0]), rd);
        end
        reg_wr(dadr(0, 4, 1'b1), 16'($urandom));
        reg_rd(dadr(0, 4, 1'b0), rd);
        check("flags cleared", dexp(fld[4], 1'b0, 1'b0), rd);
        v = 16'h8040;
        access(v, 1'b1, 1'b1, 1'b0);
        reg_rd(dadr(0, 4, 1'b0), rd);
        check("internal access", dexp(fld[4], 1'b0, 1'b0), rd);
        controlRomConsoleBit <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            if (k % 8 == 0) reg_wr(ADDR_CTRL, 16'(k / 8));
            sw = 2'($urandom);
            consoleSwitchHigh <= sw;
            displaySelectorCode <= 3'(k);
            // two sync stages plus the display register
            repeat (4) @(posedge clk_sys);
            #1;
            case (k % 8)
                0: check("display", physx(v, b, k / 8), consoleDisplayAddress);
                1: check("display", {sw, v}, consoleDisplayAddress);
                default: check("display", {2'b00, v}, consoleDisplayAddress);
            endcase
            if (k % 8 >= 2) check("space", 3'h1 << ((k % 8) / 2 - 1), spaceSelect);
            if (k % 8 >= 2) check("data space", k[0], dataSpace);
        end
        controlRomConsoleBit <= 1'b0;
        // processor mode picks the set: a write access marks that set's descriptor only
        for (int m = 0; m < 3; m++) begin
            t = 1'($urandom);
            procMode <= (m == 2) ? MODE_USER : 2'(m);
            procDataSpace <= t;
            v = 16'($urandom);
            fld[m] = (16'($urandom) & 16'hFFF8) | 16'h0006;
            reg_wr(dadr(m, {t, v[15:13]}, 1'b0), fld[m]);
            access(v, 1'b1, 1'b0, 1'b0);
            check("space", 3'h1 << m, spaceSelect);
            check("data space", t, dataSpace);
            check("trap", 1'b0, memMgmtTrap);
            reg_rd(dadr(m, {t, v[15:13]}, 1'b0), rd);
            check("mode set flags", dexp(fld[m], 1'b0, 1'b1), rd);
        end
        tally_and_finish();
    end
endmodule : pdr_unit_tb
